// *** hdl/cfp_pkg.sv ***
// Purpose: Shared constants and types for the core fetch pipeline and memory map.
// Assumes: One clock, synchronous active-high reset.
// Notes: Data addresses are physical file addresses, bank bit in bit 7.
package cfp_pkg;
   // ==========================================================
   // Widths and vectors
   localparam int PC_W = 13;
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int PROG_IMPL_BITS_DEF = 10;
   localparam logic [12:0] RESET_VECTOR = 13'h0000;
   localparam logic [12:0] INT_VECTOR = 13'h0004;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_INDIRECT_WINDOW = 8'h00;
   localparam logic [7:0] ADDR_TIMER_COUNT = 8'h01;
   localparam logic [7:0] ADDR_PC_LOW_BYTE = 8'h02;
   localparam logic [7:0] ADDR_CORE_FLAGS = 8'h03;
   localparam logic [7:0] ADDR_INDIRECT_POINTER = 8'h04;
   localparam logic [7:0] ADDR_PORT_PINS = 8'h05;
   localparam logic [7:0] ADDR_PC_UPPER_LATCH = 8'h0A;
   localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0B;
   localparam logic [7:0] ADDR_PERIPHERAL_FLAGS = 8'h0C;
   localparam logic [7:0] ADDR_CONVERSION_RESULT = 8'h1E;
   localparam logic [7:0] ADDR_CONVERTER_CONTROL_A = 8'h1F;
   localparam logic [7:0] ADDR_TIMER_OPTION = 8'h81;
   localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h85;
   localparam logic [7:0] ADDR_PERIPHERAL_INT_ENABLES = 8'h8C;
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'h8E;
   localparam logic [7:0] ADDR_OSC_TRIM = 8'h8F;
   localparam logic [7:0] ADDR_CONVERTER_CONFIG_B = 8'h9F;

   // ==========================================================
   // Map regions
   localparam logic [7:0] BANK_OFFSET_MASK = 8'h7F;
   localparam logic [7:0] COMMON_RAM_LO = 8'hF0;
   localparam logic [7:0] UNIMPL_A_LO = 8'h06;
   localparam logic [7:0] UNIMPL_A_HI = 8'h09;
   localparam logic [7:0] UNIMPL_B_LO = 8'h0D;
   localparam logic [7:0] UNIMPL_B_HI = 8'h1D;
   localparam logic [7:0] GPR_B1_LO = 8'hA0;
   localparam logic [7:0] GPR_B1_HI = 8'hBF;

   // ==========================================================
   // Fields and reset values
   localparam int FLAGS_BANK_BIT = 5;
   localparam logic [7:0] FLAGS_WRITE_MASK = 8'hE7;
   localparam logic [7:0] FLAGS_RESET = 8'h18;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] LATCH_MASK = 8'h1F;
   localparam logic [7:0] INTCTL_RESET = 8'h00;
   localparam int INTCTL_GIE_BIT = 7;

   // ==========================================================
   // Instruction decode
   localparam logic [2:0] JUMP_OPCODE = 3'h5;
   localparam logic [1:0] BYTE_OP_CLASS = 2'h0;
   localparam int DEST_BIT = 7;
   localparam logic [6:0] FILE_INDIRECT = 7'h00;

   typedef enum logic [1:0] {
      PH_ONE = 2'b00,
      PH_TWO = 2'b01,
      PH_THREE = 2'b10,
      PH_FOUR = 2'b11
   } cfp_phase_e;

   typedef struct packed {
      logic [7:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } cfp_dreq_s;
endpackage

// *** hdl/cfp_core.sv ***
// Purpose: Four-phase instruction timing, fetch/execute pipeline and data memory map.
// Assumes: CLK_IN is the oscillator input at 10 MHz; program memory answers within
//    phases two to four; the external ALU drives RESULT_IN during phases three and four.
// Notes: Branch, write to the pc low byte and interrupt entry flush one fetched word.
//
// Behaviour
// RULE1 - Oscillator input divided by four into four non-overlapping phase enables.
// RULE2 - An instruction cycle is phases one to four, in that order.
// RULE3 - Program counter increments in phase one; fetched word captured in phase four.
// RULE4 - Fetched word enters instruction register in phase one, executes phases two-four.
// RULE5 - Operand read happens in phase two, destination write in phase four.
// RULE6 - Next fetch overlaps current execute, giving one instruction per cycle.
// RULE7 - Program counter changes take two cycles; the prefetched word is discarded.
// RULE8 - Program counter is 13 bits, addressing 8K words of 14 bits.
// RULE9 - Addresses above implemented program memory wrap onto implemented words.
// RULE10 - Reset loads address 0000h; accepted interrupt loads address 0004h.
// RULE11 - Flags bit five selects bank one when set, bank zero when clear.
// RULE12 - Each bank decodes 128 bytes: special registers low, static RAM above.
// RULE13 - Bank one F0h-FFh reaches the same RAM as bank zero 70h-7Fh.
// RULE14 - Core registers answer identically at bank zero address and 80h higher.
// RULE15 - Offsets 00h and 80h redirect through the indirect pointer.
// RULE16 - Unimplemented locations read zero and ignore writes.
`timescale 1ns/1ps
module cfp_core
   import cfp_pkg::*;
#(
   parameter int PROG_IMPL_BITS = PROG_IMPL_BITS_DEF
) (
   input wire logic CLK_IN,
   input wire logic SRST_IN,
   output logic [PC_W-1:0] PROG_ADDR_OUT,
   input wire logic [INSTR_W-1:0] PROG_DATA_IN,
   output cfp_dreq_s DATA_REQ_OUT,
   input wire logic [DATA_W-1:0] DATA_RDATA_IN,
   input wire logic [DATA_W-1:0] RESULT_IN,
   input wire logic INT_REQ_IN,
   output logic [3:0] PHASE_OUT,
   output logic [INSTR_W-1:0] IR_OUT,
   output logic IR_VALID_OUT,
   output logic [DATA_W-1:0] OPERAND_OUT,
   output logic BANK_SELECT_OUT,
   output logic INT_ACK_OUT
);

   // ==========================================================
   // Address functions
   function automatic logic [7:0] fold_addr(input logic [7:0] raw);
      logic [7:0] a;
      a = raw;
      if (raw >= COMMON_RAM_LO) begin
         a = raw & BANK_OFFSET_MASK; // RULE13
      end else begin
         case (raw & BANK_OFFSET_MASK)
            ADDR_INDIRECT_WINDOW, ADDR_PC_LOW_BYTE, ADDR_CORE_FLAGS,
            ADDR_INDIRECT_POINTER, ADDR_PC_UPPER_LATCH, ADDR_INTERRUPT_CONTROL: begin
               a = raw & BANK_OFFSET_MASK; // RULE14
            end
            default: begin
               a = raw;
            end
         endcase
      end
      return a;
   endfunction

   function automatic logic is_unimpl(input logic [7:0] a);
      logic u;
      u = 1'b0;
      if (a == ADDR_INDIRECT_WINDOW) begin
         u = 1'b1; // RULE15
      end else if (a[7] == 1'b0) begin
         u = (a >= UNIMPL_A_LO && a <= UNIMPL_A_HI) ||
             (a >= UNIMPL_B_LO && a <= UNIMPL_B_HI); // RULE16
      end else begin
         case (a)
            ADDR_TIMER_OPTION, ADDR_PIN_DIRECTION, ADDR_PERIPHERAL_INT_ENABLES,
            ADDR_POWER_CONTROL, ADDR_OSC_TRIM, ADDR_CONVERTER_CONFIG_B: begin
               u = 1'b0;
            end
            default: begin
               u = !(a >= GPR_B1_LO && a <= GPR_B1_HI); // RULE12 RULE16
            end
         endcase
      end
      return u;
   endfunction

   function automatic logic [PC_W-1:0] wrap_addr(input logic [PC_W-1:0] pc);
      logic [PC_W-1:0] mask;
      mask = PC_W'((1 << PROG_IMPL_BITS) - 1);
      return pc & mask; // RULE9
   endfunction

   // ==========================================================
   // State
   cfp_phase_e phase_reg;
   logic [PC_W-1:0] pc_reg; // RULE8
   logic [INSTR_W-1:0] fetch_word_reg;
   logic fetch_valid_reg;
   logic [INSTR_W-1:0] ir_reg;
   logic ir_valid_reg;
   logic [7:0] eff_addr_reg;
   logic [7:0] flags_reg;
   logic [7:0] pointer_reg;
   logic [7:0] latch_reg;
   logic [7:0] intctl_reg;
   logic [7:0] raw_addr;
   logic [7:0] next_addr;
   logic [7:0] read_value;
   logic is_jump;
   logic writes_file;
   logic write_live;
   logic pcl_write;
   logic redirect;
   logic int_take;
   logic [PC_W-1:0] target;
   logic [PC_W-1:0] pc_next;

   // ==========================================================
   // Phase generator
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         phase_reg <= PH_ONE;
         PHASE_OUT <= 4'h1;
      end else begin
         unique case (phase_reg)
            PH_ONE: begin
               phase_reg <= PH_TWO; // RULE1 RULE2
               PHASE_OUT <= 4'h2;
            end
            PH_TWO: begin
               phase_reg <= PH_THREE;
               PHASE_OUT <= 4'h4;
            end
            PH_THREE: begin
               phase_reg <= PH_FOUR;
               PHASE_OUT <= 4'h8;
            end
            PH_FOUR: begin
               phase_reg <= PH_ONE;
               PHASE_OUT <= 4'h1;
            end
         endcase
      end
   end

   // ==========================================================
   // Decode and redirect
   always_comb begin
      raw_addr = (fetch_word_reg[6:0] == FILE_INDIRECT) ? pointer_reg :
                 {flags_reg[FLAGS_BANK_BIT], fetch_word_reg[6:0]}; // RULE11 RULE15
      next_addr = fold_addr(raw_addr);
      is_jump = ir_valid_reg && (ir_reg[13:11] == JUMP_OPCODE);
      writes_file = ir_valid_reg && (ir_reg[13:12] == BYTE_OP_CLASS) && ir_reg[DEST_BIT];
      write_live = writes_file && !is_unimpl(eff_addr_reg); // RULE16
      pcl_write = write_live && (eff_addr_reg == ADDR_PC_LOW_BYTE);
      redirect = is_jump || pcl_write; // RULE7
      int_take = !redirect && INT_REQ_IN && intctl_reg[INTCTL_GIE_BIT];
      if (is_jump) begin
         target = {latch_reg[4:3], ir_reg[10:0]};
      end else begin
         target = {latch_reg[4:0], RESULT_IN};
      end
      if (int_take) begin
         pc_next = INT_VECTOR; // RULE10
      end else begin
         pc_next = target;
      end
   end

   // ==========================================================
   // Program counter and fetch
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         pc_reg <= RESET_VECTOR; // RULE10
         PROG_ADDR_OUT <= RESET_VECTOR;
         fetch_word_reg <= '0;
         fetch_valid_reg <= 1'b0;
         INT_ACK_OUT <= 1'b0;
      end else begin
         INT_ACK_OUT <= 1'b0;
         if (phase_reg == PH_ONE) begin
            PROG_ADDR_OUT <= wrap_addr(pc_reg); // RULE9
            pc_reg <= pc_reg + 13'h0001; // RULE3
         end
         if (phase_reg == PH_FOUR) begin
            fetch_word_reg <= PROG_DATA_IN; // RULE3 RULE6
            fetch_valid_reg <= !(redirect || int_take); // RULE7
            if (redirect || int_take) begin
               pc_reg <= pc_next;
            end
            INT_ACK_OUT <= int_take;
         end
      end
   end

   // ==========================================================
   // Instruction register
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         ir_reg <= '0;
         ir_valid_reg <= 1'b0;
         IR_OUT <= '0;
         IR_VALID_OUT <= 1'b0;
      end else if (phase_reg == PH_ONE) begin
         ir_reg <= fetch_word_reg; // RULE4 RULE6
         ir_valid_reg <= fetch_valid_reg;
         IR_OUT <= fetch_word_reg;
         IR_VALID_OUT <= fetch_valid_reg;
      end
   end

   // ==========================================================
   // Data memory access
   always_comb begin
      if (is_unimpl(eff_addr_reg)) begin
         read_value = 8'h00; // RULE16
      end else begin
         case (eff_addr_reg)
            ADDR_PC_LOW_BYTE: begin
               read_value = pc_reg[7:0];
            end
            ADDR_CORE_FLAGS: begin
               read_value = flags_reg;
            end
            ADDR_INDIRECT_POINTER: begin
               read_value = pointer_reg;
            end
            ADDR_PC_UPPER_LATCH: begin
               read_value = latch_reg & LATCH_MASK;
            end
            ADDR_INTERRUPT_CONTROL: begin
               read_value = intctl_reg;
            end
            default: begin
               read_value = DATA_RDATA_IN;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         eff_addr_reg <= 8'h00;
         DATA_REQ_OUT <= '0;
         OPERAND_OUT <= 8'h00;
      end else begin
         unique case (phase_reg)
            PH_ONE: begin
               eff_addr_reg <= next_addr; // RULE12
               DATA_REQ_OUT.addr <= next_addr;
               DATA_REQ_OUT.rd <= fetch_valid_reg && !is_unimpl(next_addr); // RULE5
            end
            PH_TWO: begin
               DATA_REQ_OUT.rd <= 1'b0;
               OPERAND_OUT <= read_value; // RULE5
            end
            PH_THREE: begin
               DATA_REQ_OUT.wr <= write_live; // RULE5
               DATA_REQ_OUT.wdata <= RESULT_IN;
            end
            PH_FOUR: begin
               DATA_REQ_OUT.wr <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Core registers
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         flags_reg <= FLAGS_RESET;
         pointer_reg <= POINTER_RESET;
         latch_reg <= LATCH_RESET;
         intctl_reg <= INTCTL_RESET;
         BANK_SELECT_OUT <= FLAGS_RESET[FLAGS_BANK_BIT];
      end else if (phase_reg == PH_FOUR) begin
         if (write_live) begin
            case (eff_addr_reg)
               ADDR_CORE_FLAGS: begin
                  flags_reg <= (flags_reg & ~FLAGS_WRITE_MASK) |
                               (RESULT_IN & FLAGS_WRITE_MASK);
                  BANK_SELECT_OUT <= RESULT_IN[FLAGS_BANK_BIT]; // RULE11
               end
               ADDR_INDIRECT_POINTER: begin
                  pointer_reg <= RESULT_IN;
               end
               ADDR_PC_UPPER_LATCH: begin
                  latch_reg <= RESULT_IN & LATCH_MASK;
               end
               ADDR_INTERRUPT_CONTROL: begin
                  intctl_reg <= RESULT_IN;
               end
               default: begin
               end
            endcase
         end
         if (int_take) begin
            intctl_reg[INTCTL_GIE_BIT] <= 1'b0; // RULE10
         end
      end
   end

endmodule

// *** verification/cfp_mem_model.sv ***
// Purpose: Program memory, external data file and ALU stand-in for the core.
// Assumes: The bench loads the word table and the result table before reset ends.
// Notes: Read data shows the inverted cell while rd is low, so stale reads show up.
`timescale 1ns/1ps
module cfp_mem_model
   import cfp_pkg::*;
(
   input wire logic clk_in,
   input wire logic [PC_W-1:0] addr_in,
   input wire cfp_dreq_s req_in,
   input wire logic [INSTR_W-1:0] ir_in,
   output logic [INSTR_W-1:0] word_out,
   output logic [DATA_W-1:0] rdata_out,
   output logic [DATA_W-1:0] result_out
);
   logic [INSTR_W-1:0] rom [1024] = '{default: 14'h0020};
   logic [DATA_W-1:0] ram [256] = '{default: 8'hEE};
   logic [DATA_W-1:0] alu [128] = '{default: 8'h00};
   assign word_out = rom[addr_in[9:0]];
   assign rdata_out = req_in.rd ? ram[req_in.addr] : ~ram[req_in.addr];
   assign result_out = alu[ir_in[6:0]];
   always @(posedge clk_in) begin
      if (req_in.wr) begin
         ram[req_in.addr] <= req_in.wdata;
      end
   end
endmodule

// *** verification/cfp_core_sva.sv ***
// Purpose: Port-level checks of phase timing, fetch and data map.
// Assumes: Bound to every core instance.
// Notes: Phase outputs are one-hot enables lasting one clock each.
`timescale 1ns/1ps
module cfp_core_sva
   import cfp_pkg::*;
#(
   parameter int PROG_IMPL_BITS = PROG_IMPL_BITS_DEF
) (
   input wire logic CLK_IN,
   input wire logic SRST_IN,
   input wire logic [PC_W-1:0] PROG_ADDR_OUT,
   input wire cfp_dreq_s DATA_REQ_OUT,
   input wire logic [3:0] PHASE_OUT,
   input wire logic [INSTR_W-1:0] IR_OUT,
   input wire logic IR_VALID_OUT,
   input wire logic INT_ACK_OUT
);
   default clocking @(posedge CLK_IN);
   endclocking
   default disable iff (SRST_IN);
   logic busy;
   assign busy = DATA_REQ_OUT.rd | DATA_REQ_OUT.wr;
   property p_onehot;
      $onehot(PHASE_OUT);
   endproperty
   a_onehot: assert property (p_onehot) else $error("phase not one-hot");
   property p_rotate;
      !$past(SRST_IN) |-> PHASE_OUT == {$past(PHASE_OUT[2:0]), $past(PHASE_OUT[3])};
   endproperty
   a_rotate: assert property (p_rotate) else $error("phase order broken");
   property p_addr_hold;
      !$past(PHASE_OUT[0]) && !$past(SRST_IN) |-> $stable(PROG_ADDR_OUT);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");
   property p_ir_hold;
      !$past(PHASE_OUT[0]) && !$past(SRST_IN) |-> $stable(IR_OUT);
   endproperty
   a_ir_hold: assert property (p_ir_hold) else $error("instruction moved");
   property p_rd;
      DATA_REQ_OUT.rd |-> PHASE_OUT == 4'h2;
   endproperty
   a_rd: assert property (p_rd) else $error("read outside phase two");
   property p_wr;
      DATA_REQ_OUT.wr |-> PHASE_OUT == 4'h8;
   endproperty
   a_wr: assert property (p_wr) else $error("write outside phase four");
   property p_flush;
      PHASE_OUT[3] && IR_VALID_OUT && IR_OUT[13:11] == JUMP_OPCODE |-> ##2 !IR_VALID_OUT;
   endproperty
   a_flush: assert property (p_flush) else $error("jump did not flush");
   property p_wrap;
      (PROG_ADDR_OUT >> PROG_IMPL_BITS) == '0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("fetch address not wrapped");
   property p_vector;
      INT_ACK_OUT |-> PHASE_OUT[0] ##1 PROG_ADDR_OUT == INT_VECTOR;
   endproperty
   a_vector: assert property (p_vector) else $error("vector not fetched");
   property p_common;
      busy |-> DATA_REQ_OUT.addr < COMMON_RAM_LO;
   endproperty
   a_common: assert property (p_common) else $error("common RAM not folded");
   property p_unimpl;
      busy |-> !(DATA_REQ_OUT.addr[6:0] inside {[UNIMPL_A_LO:UNIMPL_A_HI]});
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("access to empty place");
endmodule
bind cfp_core cfp_core_sva #(.PROG_IMPL_BITS(PROG_IMPL_BITS)) u_sva (
   .CLK_IN(CLK_IN),
   .SRST_IN(SRST_IN),
   .PROG_ADDR_OUT(PROG_ADDR_OUT),
   .DATA_REQ_OUT(DATA_REQ_OUT),
   .PHASE_OUT(PHASE_OUT),
   .IR_OUT(IR_OUT),
   .IR_VALID_OUT(IR_VALID_OUT),
   .INT_ACK_OUT(INT_ACK_OUT)
);

// *** verification/cfp_core_tb_top.sv ***
// Purpose: Self-checking run of the fetch pipeline and data map.
// Assumes: 1K-word program memory variant.
// Notes: Write results come from a table keyed by the file field.
`timescale 1ns/1ps
module cfp_core_tb_top
   import cfp_pkg::*;
;
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic int_req = 1'h0;
   logic [PC_W-1:0] paddr;
   logic [INSTR_W-1:0] word;
   logic [INSTR_W-1:0] ir;
   cfp_dreq_s dreq;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] result;
   logic [3:0] phase;
   logic bank;
   logic ack;
   logic ir_valid;
   logic [DATA_W-1:0] operand;
   logic jumped = 1'h0;
   logic [PC_W-1:0] last_addr = '0;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [INSTR_W-1:0] prog [8] = '{14'h00A0, 14'h0083, 14'h00F0, 14'h0084,
      14'h0080, 14'h0086, 14'h008B, 14'h2C0C};
   cfp_core #(.PROG_IMPL_BITS(10)) uut (
      .CLK_IN(clk),
      .SRST_IN(srst),
      .PROG_ADDR_OUT(paddr),
      .PROG_DATA_IN(word),
      .DATA_REQ_OUT(dreq),
      .DATA_RDATA_IN(rdata),
      .RESULT_IN(result),
      .INT_REQ_IN(int_req),
      .PHASE_OUT(phase),
      .IR_OUT(ir),
      .IR_VALID_OUT(ir_valid),
      .OPERAND_OUT(operand),
      .BANK_SELECT_OUT(bank),
      .INT_ACK_OUT(ack)
   );
   cfp_mem_model m (
      .clk_in(clk),
      .addr_in(paddr),
      .req_in(dreq),
      .ir_in(ir),
      .word_out(word),
      .rdata_out(rdata),
      .result_out(result)
   );
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Tracks fetch addresses and cuts a hang short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (paddr !== last_addr) begin
         jumped <= jumped | (last_addr == 13'h0008 && paddr == 13'h000C);
         last_addr <= paddr;
      end
      if (cycles == 2000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic t_reset();
      repeat (4) tick();
      srst = 1'h0;
      check("phase", 16'h0001, {12'h000, phase});
      check("fetch address", 16'h0000, {3'h0, paddr});
   endtask
   task automatic t_program();
      repeat (26) tick();
      check("empty read", 16'h0000, {8'h00, operand});
      repeat (10) tick();
      check("gpr", 16'h005A, {8'h00, m.ram[8'h20]});
      check("bank", 16'h0001, {15'h0000, bank});
      check("common", 16'h003C, {8'h00, m.ram[8'h70]});
      check("indirect", 16'h0099, {8'h00, m.ram[8'h21]});
      check("empty", 16'h00EE, {8'h00, m.ram[8'h86]});
   endtask
   task automatic t_jump();
      repeat (16) tick();
      check("jump", 16'h0001, {15'h0000, jumped});
      check("operand", 16'h00EE, {8'h00, operand});
      check("ir", 16'h0020, {2'h0, ir});
      check("ir valid", 16'h0001, {15'h0000, ir_valid});
   endtask
   task automatic t_irq();
      int n = 0;
      int_req = 1'h1;
      while (ack !== 1'h1 && n < 8) begin
         tick();
         n++;
      end
      int_req = 1'h0;
      check("ack", 16'h0001, {15'h0000, ack});
      tick();
      check("vector", 16'h0004, {3'h0, paddr});
      check("ack pulse", 16'h0000, {15'h0000, ack});
      check("flush", 16'h0000, {15'h0000, ir_valid});
      int_req = 1'h1;
      repeat (3) tick();
      int_req = 1'h0;
      check("masked", 16'h0000, {15'h0000, ack});
   endtask
   initial begin
      for (int i = 0; i < 8; i++) begin
         m.rom[i] = prog[i];
      end
      m.alu[7'h20] = 8'h5A;
      m.alu[7'h03] = 8'h20;
      m.alu[7'h70] = 8'h3C;
      m.alu[7'h04] = 8'h21;
      m.alu[7'h00] = 8'h99;
      m.alu[7'h06] = 8'h77;
      m.alu[7'h0B] = 8'h80;
      t_reset();
      t_program();
      t_jump();
      t_irq();
      print_verdict();
   end
endmodule
